// >>> hdl/smv_lookup.sv
// Purpose: learned-address table, vlan table, lookup and indirect access
// Assumes: requests come from logic on mclk
// Notes: learned table is hashed, one slot per key hash
`include "smv_consts.svh"
`timescale 1ns/100ps
`default_nettype none
// Contract
// - learned table: 1024 entries of 72 bits, software read only, filled by learning
// - bit 71 reads 1 while entry not ready; software rereads until 0
// - bit 66 reads 1 when table holds no valid entry; resets to 1
// - bits 65-56 give valid entries minus one; zero with empty meaning none
// - bits 55-54 show the entry's two-bit aging counter
// - bits 53-52 give the learning port: 00 port 1, 01 port 2, 10 port 3
// - entry holds filter id in bits 51-48 and address in 47-0
// - command 0x1800 reads learned entry 0 into the data words
// - read word 1 first, restart if busy, then words 3, 2, 5, 4
// - vlan table consulted only when vlan mode bit 15 of global control 2 set
// - vlan table holds 16 entries of 20 bits, read and write by software
// - vlan bit 19 marks entry valid; resets to 1
// - vlan bits 18-16 are membership, bit 0 port 1, reset 111, flood set
// - vlan bits 15-12 filter id, reset 0; lookups use filter id plus address
// - vlan bits 11-0 hold the vid matched against packet vid, reset 0x001
// - untagged or null vid packets take the port default vid
// - vid matching no valid entry: drop packet, learn nothing
// - destination lookup picks egress; miss floods members except ingress port
// - source lookup miss learns filter id plus source address
// - command 0x1402 reads vlan_map_entry 2 into words 5 and 4
// - load words 5 and 4, then command 0x1406 commits vlan_map_entry 6
// - configured table hit overrides learned result; configured entries never age
module smv_lookup #(
  parameter int DYN_DEPTH = `SMV_DYN_DEPTH,
  parameter int AW = 10,
  parameter int AGE_CYC = `SMV_AGE_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic pkt_valid,
  output logic pkt_ready,
  input wire logic [1:0] pkt_port,
  input wire logic pkt_tagged,
  input wire logic [11:0] pkt_vid,
  input wire logic [47:0] pkt_da,
  input wire logic [47:0] pkt_sa,
  input wire logic [35:0] port_def_vid,
  input wire logic static_hit,
  input wire logic [2:0] static_ports,
  output logic fwd_valid,
  output logic [2:0] fwd_ports,
  output logic fwd_drop,
  output logic fwd_learn
);
  localparam int CW = AW + 1;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [AW-1:0] key_hash(input logic [3:0] filter_identifier, input logic [47:0] mac);
    logic [51:0] k;
    logic [AW-1:0] h;
    k = {filter_identifier, mac};
    h = '0;
    for (int i = 0; i < 52; i++) begin
      h[i % AW] = h[i % AW] ^ k[i];
    end
    return h;
  endfunction : key_hash
  function automatic logic [2:0] port_bit(input logic [1:0] p);
    return 3'h1 << p;
  endfunction : port_bit
  function automatic logic [9:0] cnt_fld(input logic [CW-1:0] c);
    logic [CW-1:0] m;
    m = (c == '0) ? '0 : c - 1'b1;
    return m[9:0];
  endfunction : cnt_fld
  ////////////////////////////////////////////////////////////////////////
  smv_pkg::smv_lk_t st_q;
  smv_pkg::smv_tbl_t cmd_tbl;
  smv_pkg::smv_dyn_t mem [DYN_DEPTH];
  smv_pkg::smv_dyn_t mem_rd_q, sw_ent;
  logic [19:0] vlan_q [`SMV_VLAN_DEPTH];
  logic [DYN_DEPTH-1:0] valid_q;
  logic [CW-1:0] cnt_q;
  logic [AW-1:0] sw_idx_q, da_idx, sa_idx, rd_idx;
  logic [47:0] p_da_q, p_sa_q;
  logic [31:0] div_q;
  logic [19:0] vl_wdat;
  logic [15:0] gcr2_q, dw2_q, dw3_q, dw4_q, dw5_q, rdata_q;
  logic [11:0] vid_sel;
  logic [6:0] dw1_q;
  logic [3:0] p_fid_q, vl_idx;
  logic [2:0] p_memb_q, p_sports_q, p_dest_q, fwd_ports_q;
  logic [1:0] age_q, p_port_q;
  logic [71:0] img;
  logic vpend_q, pend_q, svc_q, p_vok_q, p_shit_q, fwd_valid_q, fwd_drop_q, fwd_learn_q;
  logic cmd_wr, vl_wr, vl_rd, dyn_rd, sw_busy, accept, learn_wr, da_hit, sa_hit, vl_hit;

  ////////////////////////////////////////////////////////////////////////
  // command decode
  assign cmd_wr = reg_wr && (reg_addr == `SMV_REG_CMD);
  assign cmd_tbl = smv_pkg::smv_tbl_t'(reg_wdata[`SMV_CMD_TBL]);
  // a vlan command commits when its read bit is clear or data words were loaded since the last command
  assign vl_wr = cmd_wr && (cmd_tbl == smv_pkg::SMV_TB_VLAN) && (!reg_wdata[`SMV_CMD_RD] || vpend_q);
  assign vl_rd = cmd_wr && (cmd_tbl == smv_pkg::SMV_TB_VLAN) && reg_wdata[`SMV_CMD_RD] && !vpend_q;
  // learned table has no write path
  assign dyn_rd = cmd_wr && (cmd_tbl == smv_pkg::SMV_TB_DYN) && reg_wdata[`SMV_CMD_RD];
  assign vl_wdat = {dw5_q[3:0], dw4_q};
  assign sw_busy = pend_q | svc_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gcr2_q <= `SMV_GCR2_RST;
    end else if (reg_wr && reg_addr == `SMV_REG_GCR2) begin
      gcr2_q <= reg_wdata;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      vpend_q <= 1'b0;
    end else if (cmd_wr) begin
      vpend_q <= 1'b0;
    end else if (reg_wr && (reg_addr == `SMV_REG_DW4 || reg_addr == `SMV_REG_DW5)) begin
      vpend_q <= 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `SMV_VLAN_DEPTH; i++) begin
        vlan_q[i] <= `SMV_VLAN_RST;
      end
    end else if (vl_wr) begin
      vlan_q[reg_wdata[3:0]] <= vl_wdat;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // vid assignment and vlan match, lowest index wins
  always_comb begin
    case (pkt_port)
      2'h1: vid_sel = port_def_vid[23:12];
      2'h2: vid_sel = port_def_vid[35:24];
      default: vid_sel = port_def_vid[11:0];
    endcase
    if (pkt_tagged && pkt_vid != 12'h000) begin
      vid_sel = pkt_vid;
    end
    vl_hit = 1'b0;
    vl_idx = 4'h0;
    for (int i = `SMV_VLAN_DEPTH - 1; i >= 0; i--) begin
      if (vlan_q[i][`SMV_VL_VALID] && vlan_q[i][`SMV_VL_VID] == vid_sel) begin
        vl_hit = 1'b1;
        vl_idx = 4'(i);
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // lookup sequencer; software reads take the memory port ahead of packets
  assign pkt_ready = (st_q == smv_pkg::SMV_LK_IDLE) && !pend_q;
  assign accept = pkt_valid && pkt_ready;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= smv_pkg::SMV_LK_IDLE;
    end else begin
      case (st_q)
        smv_pkg::SMV_LK_IDLE: if (accept) st_q <= smv_pkg::SMV_LK_DA;
        smv_pkg::SMV_LK_DA: st_q <= smv_pkg::SMV_LK_SA;
        smv_pkg::SMV_LK_SA: st_q <= smv_pkg::SMV_LK_DONE;
        smv_pkg::SMV_LK_DONE: st_q <= smv_pkg::SMV_LK_IDLE;
        default: st_q <= smv_pkg::SMV_LK_IDLE;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      p_port_q <= 2'h0;
      p_da_q <= 48'h0;
      p_sa_q <= 48'h0;
      p_fid_q <= 4'h0;
      p_memb_q <= 3'h0;
      p_vok_q <= 1'b0;
      p_shit_q <= 1'b0;
      p_sports_q <= 3'h0;
    end else if (accept) begin
      p_port_q <= pkt_port;
      p_da_q <= pkt_da;
      p_sa_q <= pkt_sa;
      p_shit_q <= static_hit;
      p_sports_q <= static_ports;
      if (gcr2_q[`SMV_GCR2_VLAN]) begin
        p_vok_q <= vl_hit;
        p_fid_q <= vlan_q[vl_idx][`SMV_VL_FID];
        p_memb_q <= vlan_q[vl_idx][`SMV_VL_MEMB];
      end else begin
        p_vok_q <= 1'b1;
        p_fid_q <= 4'h0;
        p_memb_q <= 3'h7;
      end
    end
  end

  assign da_idx = key_hash(p_fid_q, p_da_q);
  assign sa_idx = key_hash(p_fid_q, p_sa_q);
  assign da_hit = valid_q[da_idx] && mem_rd_q.filter_identifier == p_fid_q && mem_rd_q.mac == p_da_q;
  assign sa_hit = valid_q[sa_idx] && mem_rd_q.filter_identifier == p_fid_q && mem_rd_q.mac == p_sa_q;
  assign learn_wr = (st_q == smv_pkg::SMV_LK_DONE) && p_vok_q;
  always_comb begin
    case (st_q)
      smv_pkg::SMV_LK_DA: rd_idx = da_idx;
      smv_pkg::SMV_LK_SA: rd_idx = sa_idx;
      default: rd_idx = sw_idx_q;
    endcase
  end
  always_ff @(posedge mclk) begin
    mem_rd_q <= mem[rd_idx];
  end
  // a hit refreshes stamp and port, a miss takes the slot
  always_ff @(posedge mclk) begin
    if (learn_wr) begin
      mem[sa_idx] <= '{age: age_q, port: p_port_q, filter_identifier: p_fid_q, mac: p_sa_q};
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      valid_q <= '0;
      cnt_q <= '0;
    end else if (learn_wr && !valid_q[sa_idx]) begin
      valid_q[sa_idx] <= 1'b1;
      cnt_q <= cnt_q + 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      p_dest_q <= 3'h0;
    end else if (st_q == smv_pkg::SMV_LK_SA) begin
      if (p_shit_q) begin
        p_dest_q <= p_sports_q;
      end else if (da_hit) begin
        p_dest_q <= port_bit(mem_rd_q.port);
      end else begin
        p_dest_q <= p_memb_q & ~port_bit(p_port_q);
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fwd_valid_q <= 1'b0;
      fwd_ports_q <= 3'h0;
      fwd_drop_q <= 1'b0;
      fwd_learn_q <= 1'b0;
    end else begin
      fwd_valid_q <= st_q == smv_pkg::SMV_LK_DONE;
      if (st_q == smv_pkg::SMV_LK_DONE) begin
        fwd_drop_q <= !p_vok_q;
        fwd_learn_q <= p_vok_q && !sa_hit;
        fwd_ports_q <= p_vok_q ? p_dest_q : 3'h0;
      end
    end
  end
  // aging stamp advances on a divided tick
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 32'h0;
      age_q <= 2'h0;
    end else if (div_q == 32'(AGE_CYC - 1)) begin
      div_q <= 32'h0;
      age_q <= age_q + 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // learned-table read: wait for an idle slot, then latch the image
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
      svc_q <= 1'b0;
      sw_idx_q <= '0;
    end else begin
      svc_q <= pend_q && st_q == smv_pkg::SMV_LK_IDLE && !dyn_rd;
      if (dyn_rd) begin
        pend_q <= 1'b1;
        sw_idx_q <= AW'(reg_wdata[`SMV_CMD_IDX]);
      end else if (pend_q && st_q == smv_pkg::SMV_LK_IDLE) begin
        pend_q <= 1'b0;
      end
    end
  end

  assign sw_ent = valid_q[sw_idx_q] ? mem_rd_q : smv_pkg::smv_dyn_t'('0);
  assign img = {1'b0, 4'h0, cnt_q == '0, cnt_fld(cnt_q), sw_ent};
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dw1_q <= `SMV_DW1_RST;
      dw2_q <= 16'h0;
      dw3_q <= 16'h0;
      dw4_q <= 16'h0;
      dw5_q <= 16'h0;
    end else if (svc_q) begin
      dw1_q <= img[70:64];
      dw3_q <= img[63:48];
      dw2_q <= img[47:32];
      dw5_q <= img[31:16];
      dw4_q <= img[15:0];
    end else if (vl_rd) begin
      dw5_q <= {12'h000, vlan_q[reg_wdata[3:0]][19:16]};
      dw4_q <= vlan_q[reg_wdata[3:0]][15:0];
    end else if (reg_wr) begin
      case (reg_addr)
        `SMV_REG_DW2: dw2_q <= reg_wdata;
        `SMV_REG_DW3: dw3_q <= reg_wdata;
        `SMV_REG_DW4: dw4_q <= reg_wdata;
        `SMV_REG_DW5: dw5_q <= reg_wdata;
        default: dw2_q <= dw2_q;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 16'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `SMV_REG_DW1: rdata_q <= {8'h00, sw_busy, dw1_q};
        `SMV_REG_DW2: rdata_q <= dw2_q;
        `SMV_REG_DW3: rdata_q <= dw3_q;
        `SMV_REG_DW4: rdata_q <= dw4_q;
        `SMV_REG_DW5: rdata_q <= dw5_q;
        `SMV_REG_GCR2: rdata_q <= gcr2_q;
        default: rdata_q <= 16'h0;
      endcase
    end
  end
  assign reg_rdata = rdata_q;
  assign fwd_valid = fwd_valid_q;
  assign fwd_ports = fwd_ports_q;
  assign fwd_drop = fwd_drop_q;
  assign fwd_learn = fwd_learn_q;
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  cnt_bound_a: assert property (cnt_q <= CW'(DYN_DEPTH)) else $error("entry count beyond depth");
  busy_set_a: assert property (dyn_rd |=> sw_busy ##[0:6] !sw_busy) else $error("read busy window wrong");
  empty_img_a: assert property (svc_q |=> dw1_q[2] == ($past(cnt_q) == '0)) else $error("empty flag wrong");
  cnt_img_a: assert property (svc_q |=> {dw1_q[1:0], dw3_q[15:8]} == cnt_fld($past(cnt_q)))
    else $error("count field wrong");
  mode_off_a: assert property (accept && !gcr2_q[`SMV_GCR2_VLAN] |=> p_vok_q && p_fid_q == 4'h0)
    else $error("vlan used while mode off");
  vid_pick_a: assert property (pkt_tagged && pkt_vid != 12'h000 |-> vid_sel == pkt_vid)
    else $error("tagged vid not kept");
  drop_path_a: assert property (st_q == smv_pkg::SMV_LK_DONE && !p_vok_q |=> fwd_drop_q && !fwd_learn_q
    && fwd_ports_q == 3'h0) else $error("unknown vid not dropped");
  fwd_lat_a: assert property (accept |-> ##4 fwd_valid_q) else $error("lookup result late");
  flood_set_a: assert property (st_q == smv_pkg::SMV_LK_SA && !p_shit_q && !da_hit
    |=> p_dest_q == ($past(p_memb_q) & ~port_bit($past(p_port_q)))) else $error("flood set wrong");
  learn_new_a: assert property (learn_wr && !sa_hit |=> fwd_learn_q && valid_q[$past(sa_idx)])
    else $error("source miss not learned");
  vlan_commit_a: assert property (vl_wr |=> vlan_q[$past(reg_wdata[3:0])] == $past(vl_wdat))
    else $error("vlan_map_entry not committed");
  static_win_a: assert property (st_q == smv_pkg::SMV_LK_SA && p_shit_q |=> p_dest_q == $past(p_sports_q))
    else $error("configured result not used");
  age_tick_a: assert property (div_q == 32'(AGE_CYC - 1) |=> age_q == $past(age_q) + 2'h1)
    else $error("aging stamp stuck");
  learn_c: cover property (accept ##4 fwd_learn_q);
  drop_c: cover property (fwd_valid_q && fwd_drop_q);
  vlan_wr_c: cover property (vl_wr);
  dyn_rd_c: cover property (svc_q ##1 !sw_busy);
endmodule : smv_lookup
`default_nettype wire

// >>> pkg/smv_consts.svh
// Purpose: numeric constants of the switch lookup tables
// Assumes: 16-bit register port indexed by reg_addr
// Notes: definitions only
`ifndef SMV_CONSTS_SVH
`define SMV_CONSTS_SVH
`define SMV_REG_CMD 3'h0
`define SMV_REG_DW1 3'h1
`define SMV_REG_DW2 3'h2
`define SMV_REG_DW3 3'h3
`define SMV_REG_DW4 3'h4
`define SMV_REG_DW5 3'h5
`define SMV_REG_GCR2 3'h6
`define SMV_CMD_RD 12
`define SMV_CMD_TBL 11:10
`define SMV_CMD_IDX 9:0
`define SMV_GCR2_VLAN 15
`define SMV_GCR2_RST 16'h0000
`define SMV_DYN_DEPTH 1024
`define SMV_VLAN_DEPTH 16
`define SMV_VLAN_RST 20'hf0001
`define SMV_VL_VALID 19
`define SMV_VL_MEMB 18:16
`define SMV_VL_FID 15:12
`define SMV_VL_VID 11:0
`define SMV_DW1_RST 7'h04
`define SMV_AGE_CYC 50000000
`endif

// >>> pkg/smv_pkg.sv
// Purpose: types of the switch lookup tables
// Assumes: nothing
// Notes: state and table codes
`default_nettype none
package smv_pkg;
  typedef enum logic [1:0] {
    SMV_LK_IDLE = 2'b00,
    SMV_LK_DA = 2'b01,
    SMV_LK_SA = 2'b10,
    SMV_LK_DONE = 2'b11
  } smv_lk_t;
  typedef enum logic [1:0] {
    SMV_TB_STATIC = 2'b00,
    SMV_TB_VLAN = 2'b01,
    SMV_TB_DYN = 2'b10,
    SMV_TB_MIB = 2'b11
  } smv_tbl_t;
  typedef struct packed {
    logic [1:0] age;
    logic [1:0] port;
    logic [3:0] filter_identifier;
    logic [47:0] mac;
  } smv_dyn_t;
endpackage : smv_pkg
`default_nettype wire

// >>> test/smv_lookup_test.sv
// Purpose: self-checking bench for the switch lookup tables
// Assumes: aging period shortened to 8 cycles
// Notes: drivers queue expected results, monitors compare them
`include "smv_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module smv_lookup_test;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic pkt_valid = 1'b0;
  logic pkt_ready;
  logic [1:0] pkt_port = 2'h0;
  logic pkt_tagged = 1'b0;
  logic [11:0] pkt_vid = 12'h000;
  logic [47:0] pkt_da = 48'h000000000000;
  logic [47:0] pkt_sa = 48'h000000000000;
  logic [35:0] port_def_vid = 36'h000000000;
  logic static_hit = 1'b0;
  logic [2:0] static_ports = 3'h0;
  logic fwd_valid;
  logic [2:0] fwd_ports;
  logic fwd_drop;
  logic fwd_learn;
  logic rd_seen = 1'b0;
  logic [31:0] rd_q [$];
  logic [4:0] fwd_q [$];
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [47:0] mac_a, mac_b, mac_c, mac_d;
  logic [11:0] vid_r;
  logic [3:0] fid_r;

  always #10 mclk = ~mclk;

  smv_lookup #(.AGE_CYC(8)) dut (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
    .pkt_port(pkt_port), .pkt_tagged(pkt_tagged), .pkt_vid(pkt_vid), .pkt_da(pkt_da),
    .pkt_sa(pkt_sa), .port_def_vid(port_def_vid), .static_hit(static_hit),
    .static_ports(static_ports), .fwd_valid(fwd_valid), .fwd_ports(fwd_ports),
    .fwd_drop(fwd_drop), .fwd_learn(fwd_learn)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // slot of a learned key: filter id and address folded onto ten bits
  function automatic logic [9:0] fold(input logic [51:0] k);
    logic [9:0] h;
    h = 10'h000;
    for (int i = 0; i < 52; i++) h[i % 10] = h[i % 10] ^ k[i];
    return h;
  endfunction : fold

  task automatic tally_and_finish;
    $display("counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge mclk) rd_seen <= reg_rd;

  // read data is settled by the falling edge after the read strobe
  always @(negedge mclk) begin
    logic [31:0] n;
    logic [4:0] f;
    if (rd_seen) begin
      if (rd_q.size() == 0) bad_count++;
      n = (rd_q.size() > 0) ? rd_q.pop_front() : 32'hffff0000;
      check(reg_rdata & n[31:16], n[15:0] & n[31:16]);
    end
    if (fwd_valid === 1'b1) begin
      f = (fwd_q.size() > 0) ? fwd_q.pop_front() : 5'h1f;
      check({11'h000, fwd_drop, fwd_learn, fwd_ports}, {11'h000, f});
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [2:0] a, input logic [15:0] e, input logic [15:0] m);
    rd_q.push_back({m, e});
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask : reg_read

  task automatic vlan_write(input logic [3:0] idx, input logic [19:0] e);
    reg_write(`SMV_REG_DW5, {12'h000, e[19:16]});
    reg_write(`SMV_REG_DW4, e[15:0]);
    reg_write(`SMV_REG_CMD, 16'h1400 | {12'h000, idx});
  endtask : vlan_write

  task automatic vlan_read(input logic [3:0] idx, input logic [19:0] e);
    reg_write(`SMV_REG_CMD, 16'h1400 | {12'h000, idx});
    reg_read(`SMV_REG_DW5, {12'h000, e[19:16]}, 16'h000f);
    reg_read(`SMV_REG_DW4, e[15:0], 16'hffff);
  endtask : vlan_read

  // word 1 first, then word 3, after the busy bit has had time to clear
  task automatic learned_read(input logic [15:0] e1, input logic [15:0] e3, input logic [15:0] m3);
    reg_write(`SMV_REG_CMD, 16'h1800);
    repeat (8) @(posedge mclk);
    reg_read(`SMV_REG_DW1, e1, 16'h00ff);
    reg_read(`SMV_REG_DW3, e3, m3);
  endtask : learned_read

  task automatic send_pkt(input logic [1:0] p, input logic t, input logic [11:0] v, input logic [47:0] da,
      input logic [47:0] sa, input logic [3:0] sh, input logic [4:0] e);
    fwd_q.push_back(e);
    @(posedge mclk);
    pkt_port <= p;
    pkt_tagged <= t;
    pkt_vid <= v;
    pkt_da <= da;
    pkt_sa <= sa;
    static_hit <= sh[3];
    static_ports <= sh[2:0];
    pkt_valid <= 1'b1;
    repeat (50) begin
      @(negedge mclk);
      if (pkt_ready === 1'b1) break;
    end
    @(posedge mclk);
    pkt_valid <= 1'b0;
    static_hit <= 1'b0;
  endtask : send_pkt

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(38240));
    mac_a = {16'h0200, $urandom()};
    mac_b = {16'h0201, $urandom()};
    mac_c = {16'h0202, $urandom()};
    mac_d = {16'h0203, $urandom()};
    vid_r = 12'h100 | 12'($urandom_range(255, 2));
    fid_r = 4'($urandom_range(15, 1));
    port_def_vid <= {12'h001, vid_r, 12'h001};
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;

    for (int i = 0; i < 16; i++) vlan_read(4'(i), `SMV_VLAN_RST);
    reg_read(`SMV_REG_CMD, 16'h0000, 16'hffff);
    reg_read(3'h7, 16'h0000, 16'hffff);
    reg_write(`SMV_REG_DW1, 16'hffff);
    reg_write(`SMV_REG_DW4, 16'hffff);
    reg_write(`SMV_REG_CMD, 16'h0800);
    learned_read(16'h0004, 16'h0000, 16'hff00);
    $display("test reset_values done");

    send_pkt(2'h0, 1'b0, 12'h000, mac_b, mac_a, 4'h0, 5'b01110);
    send_pkt(2'h1, 1'b0, 12'h000, mac_a, mac_c, 4'h0, 5'b01001);
    send_pkt(2'h2, 1'b1, 12'hfff, mac_c, mac_a, 4'h0, 5'b00010);
    send_pkt(2'h0, 1'b0, 12'h000, mac_a, mac_a, 4'he, 5'b00110);
    $display("test vlan_off done");

    reg_write(`SMV_REG_GCR2, 16'h8000);
    vlan_write(4'h6, {1'b1, 3'b011, fid_r, vid_r});
    vlan_read(4'h6, {1'b1, 3'b011, fid_r, vid_r});
    send_pkt(2'h0, 1'b1, vid_r + 12'h001, mac_a, mac_d, 4'h0, 5'b10000);
    send_pkt(2'h1, 1'b0, 12'h000, mac_a, mac_b, 4'h0, 5'b01001);
    send_pkt(2'h1, 1'b1, 12'h000, mac_b, mac_c, 4'h0, 5'b01010);
    send_pkt(2'h0, 1'b1, 12'h001, mac_c, mac_a, 4'h0, 5'b00010);
    reg_write(`SMV_REG_DW5, 16'h0003);
    reg_write(`SMV_REG_DW4, {fid_r, vid_r});
    reg_write(`SMV_REG_CMD, 16'h0406);
    vlan_read(4'h6, {1'b0, 3'b011, fid_r, vid_r});
    send_pkt(2'h1, 1'b0, 12'h000, mac_a, mac_d, 4'h0, 5'b10000);
    $display("test vlan_on done");

    learned_read(16'h0000, 16'h0300, 16'hff00);
    // full entry of a key learned on port 2; the stamp bits depend on timing and stay masked
    reg_write(`SMV_REG_CMD, 16'h1800 | {6'h00, fold({fid_r, mac_b})});
    repeat (8) @(posedge mclk);
    reg_read(`SMV_REG_DW1, 16'h0000, 16'h00ff);
    reg_read(`SMV_REG_DW3, {8'h03, 4'h1, fid_r}, 16'hff3f);
    reg_read(`SMV_REG_DW2, mac_b[47:32], 16'hffff);
    reg_read(`SMV_REG_DW5, mac_b[31:16], 16'hffff);
    reg_read(`SMV_REG_DW4, mac_b[15:0], 16'hffff);
    repeat (10) @(posedge mclk);
    $display("test learned_count done");
    if (rd_q.size() != 0 || fwd_q.size() != 0) bad_count++;
    tally_and_finish;
  end
endmodule : smv_lookup_test
`default_nettype wire
